// ===== cpp_pkg.sv
/*
 current-position preset block: shared constants.
 holds buffer-memory word addresses, discrete i/o bit positions,
 error codes and timing counts. assumes a 20 MHz clock.
*/
package cpp_pkg;
   // clock rate and derived timing
   localparam int unsigned CLK_HZ          = 20_000_000;   // system clock rate
   localparam int unsigned ERR_CLR_MS      = 12;           // error-clear detection time, ms
   localparam int unsigned ERR_CLR_CYC     = ERR_CLR_MS * (CLK_HZ / 1000); // cycles, 240000
   localparam int unsigned PRESET_RESP_US  = 2000;         // longest preset response, us
   localparam int unsigned PRESET_RESP_CYC = 2;            // preset lands in 2 cycles after edge

   // buffer memory layout (word addresses, axis 1; axis 2 adds AXIS_STRIDE)
   localparam int unsigned BM_AW           = 11;           // word address width
   localparam logic [10:0] AXIS_STRIDE     = 11'h3e8;      // 1000 words between axis sets
   localparam logic [10:0] SENSOR_LO       = 11'h000;      // sensor value, low word
   localparam logic [10:0] SENSOR_HI       = 11'h001;      // sensor value, high word
   localparam logic [10:0] POS_CW_LO       = 11'h002;      // position_cw_value low
   localparam logic [10:0] POS_CW_HI       = 11'h003;      // position_cw_value high
   localparam logic [10:0] POS_CCW_LO      = 11'h004;      // position_ccw_value low
   localparam logic [10:0] POS_CCW_HI      = 11'h005;      // position_ccw_value high
   localparam logic [10:0] ERR_CODE_ADDR   = 11'h007;      // error_code_word
   localparam logic [10:0] PRESET_LO       = 11'h2b2;      // preset_value low
   localparam logic [10:0] PRESET_HI       = 11'h2b3;      // preset_value high
   localparam logic [10:0] INHIBIT_LO      = 11'h2b6;      // preset_inhibit low
   localparam logic [10:0] INHIBIT_HI      = 11'h2b7;      // preset_inhibit high
   localparam logic [10:0] AXIS_EN_ADDR    = 11'h2be;      // axis_enable_word

   // field values
   localparam logic [15:0] AXIS_OFF_CODE   = 16'h0063;     // 99 disables sensor fault detection
   localparam logic [15:0] PRESET_HI_MAX   = 16'h00ff;     // high word limit, 16777215
   localparam logic [23:0] POS_RESET       = 24'h000000;   // position after reset
   localparam logic [15:0] ERR_NONE        = 16'h0000;     // no error stored
   localparam logic [15:0] ERR_WR_BASE     = 16'h000a;     // write-protect codes 10..15
   localparam logic [15:0] ERR_PRESET_RNG  = 16'h0020;     // preset value out of range
   localparam logic [15:0] ERR_SENSOR      = 16'h0040;     // sensor fault

   // discrete i/o bit positions (32 points each way)
   localparam int unsigned IO_POINTS       = 32;
   localparam int unsigned Y_READY         = 16;           // controller_ready_out
   localparam int unsigned Y_PRESET_A0     = 19;           // preset_command, axis 1
   localparam int unsigned Y_PRESET_A1     = 22;           // preset_command, axis 2
   localparam int unsigned Y_ERR_CLEAR     = 28;           // error_clear_out
   localparam int unsigned X_ONLINE        = 1;            // online_flag
   localparam int unsigned X_SFAULT_A0     = 4;            // sensor_fault_flag, axis 1
   localparam int unsigned X_ERROR_A0      = 5;            // error_detected_flag, axis 1
   localparam int unsigned X_SFAULT_A1     = 8;            // sensor_fault_flag, axis 2
   localparam int unsigned X_ERROR_A1      = 9;            // error_detected_flag, axis 2
endpackage : cpp_pkg

// ===== cpp_position_preset.sv
/*
 two-axis current-position tracking with preset, error flags and
 error clear, reached through a word buffer memory and 32 discrete
 points each way. assumes the controller drives the discrete outputs
 from another domain (synchronised here) and drives the buffer port
 and the sensor step inputs on clk. a new error beats a clear in the
 same cycle; positions track and presets load only while ready is high,
 and lost motion during an error is not recovered without a new preset.
*/
`timescale 1ns/1ps
module cpp_position_preset
   import cpp_pkg::*;
#(
   parameter int unsigned ERR_CLR_CYCLES = cpp_pkg::ERR_CLR_CYC   // error-clear hold count
)(
   input  wire logic                          clk,
   input  wire logic                          rst_n,
   input  wire logic [cpp_pkg::IO_POINTS-1:0] y_pins,           // controller outputs
   output      logic [cpp_pkg::IO_POINTS-1:0] x_pins,           // module inputs to controller
   input  wire logic [cpp_pkg::BM_AW-1:0]     bm_addr,          // buffer word address
   input  wire logic                          bm_wr_en,         // buffer_write_instruction strobe
   input  wire logic [15:0]                   bm_wdata,         // write word
   input  wire logic                          bm_rd_en,         // read strobe
   output      logic [15:0]                   bm_rdata,         // read word
   output      logic                          bm_rd_valid,      // read word valid
   input  wire logic [1:0]                    sens_step_valid,  // per-axis movement sample
   input  wire logic [15:0]                   sens_step_a0,     // signed cw step, axis 1
   input  wire logic [15:0]                   sens_step_a1,     // signed cw step, axis 2
   input  wire logic [1:0]                    sens_fault_pin    // per-axis raw fault
);
   import cpp_pkg::*;

   // refuse a hold count that the 24-bit counter cannot reach
   if (ERR_CLR_CYCLES < 1 || ERR_CLR_CYCLES > 32'h00ffffff) begin : g_bad_clr_cycles
      $error("ERR_CLR_CYCLES out of range");
   end

   // split address into axis and local word; axis 2 set sits 1000 above
   function automatic logic [11:0] decode_addr(input logic [10:0] a);
      logic [10:0] loc;
      logic        ax;
      // anything at or above the stride belongs to axis 2
      ax  = (a >= AXIS_STRIDE);
      loc = ax ? (a - AXIS_STRIDE) : a;
      decode_addr = {ax, loc};
   endfunction : decode_addr

   // wrap-around add of a signed step to a 24-bit position
   function automatic logic [23:0] step_pos(input logic [23:0] p, input logic [15:0] d);
      // the step is sign-extended, so backward travel subtracts
      step_pos = p + {{8{d[15]}}, d};
   endfunction : step_pos

   // synchronisers for discrete inputs and fault pins
   logic [IO_POINTS-1:0] y_meta_ff;       // first stage, read only by second
   logic [IO_POINTS-1:0] y_sync_ff;       // usable controller outputs
   logic [1:0]           flt_meta_ff;     // first stage of fault pins
   logic [1:0]           flt_sync_ff;     // usable fault levels
   logic [1:0]           preset_prev_ff;  // last preset level per axis

   // per-axis storage, index 0 is axis 1 and index 1 is axis 2
   logic [23:0] pos_cw_ff   [2];          // cw-increasing position
   logic [23:0] pos_ccw_ff  [2];          // ccw-increasing position
   logic [15:0] preset_lo_ff[2];          // preset value low word
   logic [15:0] preset_hi_ff[2];          // preset value high word
   logic [15:0] inhib_lo_ff [2];          // inhibit word, bit 0 active
   logic [15:0] inhib_hi_ff [2];          // inhibit upper word, stored only
   logic [15:0] axis_en_ff  [2];          // axis enable word
   logic [15:0] err_code_ff [2];          // error code word
   logic [1:0]  sfault_ff;                // sticky sensor fault
   logic [1:0]  err_ff;                   // sticky any error
   logic [1:0]  preset_go_ff;             // accepted preset, one cycle

   // error-clear qualification
   // the pin level must stand the full count after synchronisation
   logic [23:0] clr_cnt_ff;               // cycles error clear has stood
   logic        clr_done_ff;              // clear already issued this hold
   logic        clr_pulse_ff;             // one-cycle clear of errors

   // decoded bus access
   // combinational decode, settled before every rising edge
   logic [11:0] dec;
   logic        dec_ax;
   logic [10:0] dec_loc;
   logic        ready;
   logic [1:0]  preset_lvl;
   logic [1:0]  preset_edge;
   logic [1:0]  wr_prot;                  // illegal write per axis
   logic [1:0]  wr_range;                 // out-of-range preset write per axis
   logic [1:0]  sens_now;                 // fault seen on an enabled axis
   logic [15:0] sens_step [2];

   // decoded address and synchronised levels shared by several processes
   assign dec         = decode_addr(bm_addr);
   assign dec_ax      = dec[11];
   assign dec_loc     = dec[10:0];
   assign ready       = y_sync_ff[Y_READY];
   assign preset_lvl  = {y_sync_ff[Y_PRESET_A1], y_sync_ff[Y_PRESET_A0]};
   // an edge is a high sample whose previous sample was low
   assign preset_edge = preset_lvl & ~preset_prev_ff;
   assign sens_step[0] = sens_step_a0;
   assign sens_step[1] = sens_step_a1;

   // two-flop synchronisers for everything from outside the clock domain
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         // all-low matches the idle pins, so no false preset edge follows reset
         y_meta_ff   <= '0;
         y_sync_ff   <= '0;
         flt_meta_ff <= '0;
         flt_sync_ff <= '0;
      end else begin
         // only the second stage reads the first, never the logic
         y_meta_ff   <= y_pins;
         y_sync_ff   <= y_meta_ff;
         flt_meta_ff <= sens_fault_pin;
         flt_sync_ff <= flt_meta_ff;
      end
   end

   // per-axis error sources, decided combinationally
   always_comb begin
      for (int a = 0; a < 2; a++) begin
         // writes to sensor and position words are refused while online
         wr_prot[a]  = bm_wr_en && ready && (dec_ax == a[0]) && (dec_loc <= POS_CCW_HI);
         // high word above the 24-bit limit is out of range
         wr_range[a] = bm_wr_en && (dec_ax == a[0]) && (dec_loc == PRESET_HI) &&
                       (bm_wdata > PRESET_HI_MAX);
         // a disabled axis reports no sensor fault
         // tracking still runs on a disabled axis
         sens_now[a] = ready && flt_sync_ff[a] && (axis_en_ff[a] != AXIS_OFF_CODE);
      end
   end

   // preset edge history, tracked whatever the ready level
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         preset_prev_ff <= '0;
      end else begin
         // a level held high never yields a second edge
         preset_prev_ff <= preset_lvl;
      end
   end

   // preset acceptance: edge, online, no sensor fault, not inhibited
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         preset_go_ff <= '0;
      end else begin
         // an edge that arrives while any condition is unmet is dropped, not queued
         // the sticky fault must be cleared before presets resume
         for (int a = 0; a < 2; a++) begin
            preset_go_ff[a] <= preset_edge[a] && ready && !sfault_ff[a] &&
                               !inhib_lo_ff[a][0];
         end
      end
   end

   // writable buffer words
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         // presets zero, inhibit off, axis enabled after reset
         for (int a = 0; a < 2; a++) begin
            preset_lo_ff[a] <= '0;
            preset_hi_ff[a] <= '0;
            inhib_lo_ff[a]  <= '0;
            inhib_hi_ff[a]  <= '0;
            axis_en_ff[a]   <= '0;
         end
      end else if (bm_wr_en) begin
         // sensor and position words have no storage here; refusal is flagged below
         for (int a = 0; a < 2; a++) begin
            if (dec_ax == a[0]) begin
               unique case (dec_loc)
                  PRESET_LO:    preset_lo_ff[a] <= bm_wdata;
                  PRESET_HI: begin
                     // an out-of-range high word is refused and flagged
                     if (!wr_range[a]) begin
                        preset_hi_ff[a] <= bm_wdata;
                     end
                  end
                  INHIBIT_LO:   inhib_lo_ff[a]  <= bm_wdata;
                  INHIBIT_HI:   inhib_hi_ff[a]  <= bm_wdata;
                  AXIS_EN_ADDR: axis_en_ff[a]   <= bm_wdata;
                  default: ;
               endcase
            end
         end
      end
   end

   // position tracking and preset load
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         // positions start at zero and need a preset to mean anything
         for (int a = 0; a < 2; a++) begin
            pos_cw_ff[a]  <= POS_RESET;
            pos_ccw_ff[a] <= POS_RESET;
         end
      end else begin
         for (int a = 0; a < 2; a++) begin
            // a preset load wins over a step sample in the same cycle
            if (preset_go_ff[a]) begin
               // both forms take the stored value                                  
               pos_cw_ff[a]  <= {preset_hi_ff[a][7:0], preset_lo_ff[a]};
               pos_ccw_ff[a] <= {preset_hi_ff[a][7:0], preset_lo_ff[a]};
            end else if (ready && sens_step_valid[a]) begin
               // tracking pauses while ready is low
               // semi-absolute: steps are summed, lost motion is not recovered
               pos_cw_ff[a]  <= step_pos(pos_cw_ff[a], sens_step[a]);
               pos_ccw_ff[a] <= step_pos(pos_ccw_ff[a], 16'h0000 - sens_step[a]);
            end
         end
      end
   end

   // error clear must stand the detection time before it takes effect
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         clr_cnt_ff   <= '0;
         clr_done_ff  <= 1'b0;
         clr_pulse_ff <= 1'b0;
      end else begin
         clr_pulse_ff <= 1'b0;
         // the count restarts whenever the request drops
         if (!y_sync_ff[Y_ERR_CLEAR]) begin
            clr_cnt_ff  <= '0;
            clr_done_ff <= 1'b0;
         end else if (!clr_done_ff) begin
            // one clear per high period, however long it is held
            if (clr_cnt_ff == 24'(ERR_CLR_CYCLES - 1)) begin
               clr_pulse_ff <= 1'b1;
               clr_done_ff  <= 1'b1;
            end else begin
               // below the limit, keep counting the high time
               clr_cnt_ff <= clr_cnt_ff + 24'h000001;
            end
         end
      end
   end

   // sticky error flags and codes; a new error beats a clear
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sfault_ff <= '0;
         err_ff    <= '0;
         for (int a = 0; a < 2; a++) begin
            err_code_ff[a] <= ERR_NONE;
         end
      end else begin
         for (int a = 0; a < 2; a++) begin
            // priority: sensor fault, then range, then write protect
            // a set in the clear cycle keeps its flag, the set wins
            if (sens_now[a]) begin
               sfault_ff[a]   <= 1'b1;
               err_ff[a]      <= 1'b1;
               err_code_ff[a] <= ERR_SENSOR;
            end else if (wr_range[a]) begin
               err_ff[a]      <= 1'b1;
               err_code_ff[a] <= ERR_PRESET_RNG;
            end else if (wr_prot[a]) begin
               // protect codes run 10..15 by refused word number
               err_ff[a]      <= 1'b1;
               err_code_ff[a] <= ERR_WR_BASE + {11'h000, dec_loc[4:0]} - 16'h0000;
            end else if (clr_pulse_ff) begin
               // the latest error overwrote the code; clearing empties it
               sfault_ff[a]   <= 1'b0;
               err_ff[a]      <= 1'b0;
               err_code_ff[a] <= ERR_NONE;
            end
         end
      end
   end

   // discrete inputs toward the controller, 32 points
   // points not listed stay low; flags lag their registers one cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         x_pins <= '0;
      end else begin
         x_pins              <= '0;
         x_pins[X_ONLINE]    <= ready;
         x_pins[X_SFAULT_A0] <= sfault_ff[0];
         x_pins[X_ERROR_A0]  <= err_ff[0];
         x_pins[X_SFAULT_A1] <= sfault_ff[1];
         x_pins[X_ERROR_A1]  <= err_ff[1];
      end
   end

   // buffer read port, one cycle latency, unmapped words read zero
   // the word stands until the next read, so a slow reader still sees it
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bm_rdata    <= '0;
         bm_rd_valid <= 1'b0;
      end else begin
         bm_rd_valid <= bm_rd_en;
         if (bm_rd_en) begin
            // dec_ax picks the axis storage for every mapped word
            unique case (dec_loc)
               POS_CW_LO:     bm_rdata <= pos_cw_ff[dec_ax][15:0];
               POS_CW_HI:     bm_rdata <= {8'h00, pos_cw_ff[dec_ax][23:16]};
               POS_CCW_LO:    bm_rdata <= pos_ccw_ff[dec_ax][15:0];
               POS_CCW_HI:    bm_rdata <= {8'h00, pos_ccw_ff[dec_ax][23:16]};
               ERR_CODE_ADDR: bm_rdata <= err_code_ff[dec_ax];
               PRESET_LO:     bm_rdata <= preset_lo_ff[dec_ax];
               PRESET_HI:     bm_rdata <= preset_hi_ff[dec_ax];
               INHIBIT_LO:    bm_rdata <= inhib_lo_ff[dec_ax];
               INHIBIT_HI:    bm_rdata <= inhib_hi_ff[dec_ax];
               AXIS_EN_ADDR:  bm_rdata <= axis_en_ff[dec_ax];
               default:       bm_rdata <= '0;
            endcase
         end
      end
   end

endmodule : cpp_position_preset

// ===== cpp_host_model.sv
/*
 controller model: drives the discrete outputs and the buffer word port.
 assumes the design samples on the rising edge of the shared clk.
*/
`timescale 1ns/1ps
module cpp_host_model
   import cpp_pkg::*;
#(
   parameter int unsigned EFFECT_CYC = 20,   // write-to-preset wait, shortened for sim
   parameter int unsigned REPEAT_CYC = 40    // low time between commands, shortened
)(
   input  wire logic        clk,
   output      logic [31:0] y_pins,
   output      logic [10:0] bm_addr,
   output      logic        bm_wr_en,
   output      logic [15:0] bm_wdata,
   output      logic        bm_rd_en,
   input  wire logic [15:0] bm_rdata,
   input  wire logic        bm_rd_valid
);
   // idle levels at time zero
   initial begin
      y_pins = 32'h0;
      bm_addr = 11'h7ff;
      bm_wr_en = 1'b0;
      bm_wdata = 16'hffff;
      bm_rd_en = 1'b0;
   end
   // one word write; released lines show the inverse value
   task automatic wr(input logic [10:0] a, input logic [15:0] d);
      @(posedge clk);
      bm_addr <= a;
      bm_wdata <= d;
      bm_wr_en <= 1'b1;
      @(posedge clk);
      bm_wr_en <= 1'b0;
      bm_addr <= ~a;
      bm_wdata <= ~d;
   endtask : wr
   // two-word value, low word first, then the effect wait
   task automatic wr32(input logic [10:0] a, input logic [31:0] d);
      wr(a, d[15:0]);
      wr(a + 11'h001, d[31:16]);
      repeat (EFFECT_CYC) @(posedge clk);
   endtask : wr32
   // one word read, data taken once valid has landed
   task automatic rd(input logic [10:0] a, output logic [15:0] d);
      @(posedge clk);
      bm_addr <= a;
      bm_rd_en <= 1'b1;
      @(posedge clk);
      bm_rd_en <= 1'b0;
      bm_addr <= ~a;
      @(posedge clk);
      // valid is sampled high at this edge; the word is taken here
      d = bm_rdata;
   endtask : rd
   task automatic rd32(input logic [10:0] a, output logic [31:0] d);
      rd(a, d[15:0]);
      rd(a + 11'h001, d[31:16]);
   endtask : rd32
   task automatic set_y(input int b, input logic v);
      @(posedge clk);
      y_pins[b] <= v;
   endtask : set_y
   // command held n+1 cycles, then kept low for the repeat time
   task automatic pulse(input int b, input int n);
      set_y(b, 1'b1);
      repeat (n) @(posedge clk);
      set_y(b, 1'b0);
      repeat (REPEAT_CYC) @(posedge clk);
   endtask : pulse
endmodule : cpp_host_model

// ===== cpp_position_preset_properties.sv
/*
 checker on the preset block's ports.
 assumes axis 1 enabled and a short error-clear count in sim.
*/
`timescale 1ns/1ps
module cpp_preset_checker
   import cpp_pkg::*;
#(
   parameter int unsigned ERR_CLR_CYCLES = ERR_CLR_CYC
)(
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic [31:0] y_pins,
   input wire logic [31:0] x_pins,
   input wire logic [10:0] bm_addr,
   input wire logic        bm_wr_en,
   input wire logic [15:0] bm_wdata,
   input wire logic        bm_rd_en,
   input wire logic [15:0] bm_rdata,
   input wire logic        bm_rd_valid,
   input wire logic [1:0]  sens_step_valid,
   input wire logic [15:0] sens_step_a0,
   input wire logic [15:0] sens_step_a1,
   input wire logic [1:0]  sens_fault_pin
);
   localparam logic [31:0] X_USED = 32'h0000_0332; // flag points in use
   int unsigned clr_hi_ff;                          // cycles error clear held high
   // saturating count of the clear request's high time
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) clr_hi_ff <= 0;
      else if (!y_pins[Y_ERR_CLEAR]) clr_hi_ff <= 0;
      else if (clr_hi_ff < ERR_CLR_CYCLES) clr_hi_ff <= clr_hi_ff + 1;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_read_answer_next: assert property (bm_rd_en |=> bm_rd_valid)
      else $error("read not answered next cycle");
   a_read_data_holds: assert property (!bm_rd_valid |-> $stable(bm_rdata))
      else $error("read word moved without a read");
   a_unused_points_low: assert property ((x_pins & ~X_USED) == 32'h0)
      else $error("unused input point driven");
   a_online_with_ready: assert property (y_pins[Y_READY] [*4] |=> x_pins[X_ONLINE])
      else $error("online flag missing while ready");
   a_offline_not_ready: assert property ((!y_pins[Y_READY]) [*4] |=> !x_pins[X_ONLINE])
      else $error("online flag set without ready");
   a_fault_flag_raised: assert property ((sens_fault_pin[0] && x_pins[X_ONLINE]) [*5] |=> x_pins[X_SFAULT_A0])
      else $error("sensor fault not flagged");
   a_fault_sets_error: assert property (x_pins[X_SFAULT_A0] && $past(x_pins[X_SFAULT_A0]) |-> x_pins[X_ERROR_A0])
      else $error("sensor fault without error flag");
   a_clear_needs_hold: assert property ($fell(x_pins[X_ERROR_A0]) && y_pins[Y_READY] |-> clr_hi_ff >= ERR_CLR_CYCLES)
      else $error("error cleared by a short request");
   c_error_cleared: cover property ($fell(x_pins[X_ERROR_A0]));
   c_fault_seen: cover property ($rose(x_pins[X_SFAULT_A0]));
   c_read_done: cover property (bm_rd_valid);
endmodule : cpp_preset_checker

bind cpp_position_preset cpp_preset_checker #(.ERR_CLR_CYCLES(ERR_CLR_CYCLES)) cpp_preset_checker_inst (
   .clk(clk), .rst_n(rst_n), .y_pins(y_pins), .x_pins(x_pins), .bm_addr(bm_addr), .bm_wr_en(bm_wr_en),
   .bm_wdata(bm_wdata), .bm_rd_en(bm_rd_en), .bm_rdata(bm_rdata), .bm_rd_valid(bm_rd_valid),
   .sens_step_valid(sens_step_valid), .sens_step_a0(sens_step_a0), .sens_step_a1(sens_step_a1),
   .sens_fault_pin(sens_fault_pin));

// ===== testbench.sv
/*
 self-checking bench for the preset block, one task per scenario.
 assumes the controller model instance drives pins and buffer port.
*/
`timescale 1ns/1ps
module testbench;
   import cpp_pkg::*;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [31:0] y_pins, x_pins;
   logic [10:0] bm_addr;
   logic        bm_wr_en, bm_rd_en, bm_rd_valid;
   logic [15:0] bm_wdata, bm_rdata;
   logic [1:0]  sens_step_valid = 2'b00;
   logic [15:0] sens_step_a0 = 16'h0;
   logic [15:0] sens_step_a1 = 16'h0;
   logic [1:0]  sens_fault_pin = 2'b00;
   int          fail_count = 0;
   int          check_count = 0;
   localparam logic [31:0] PV = 32'h0012_3456; // axis 1 preset value
   always #25 clk = ~clk;
   cpp_position_preset #(.ERR_CLR_CYCLES(8)) cpp_position_preset_inst (.clk(clk), .rst_n(rst_n),
      .y_pins(y_pins), .x_pins(x_pins), .bm_addr(bm_addr), .bm_wr_en(bm_wr_en), .bm_wdata(bm_wdata),
      .bm_rd_en(bm_rd_en), .bm_rdata(bm_rdata), .bm_rd_valid(bm_rd_valid), .sens_step_valid(sens_step_valid),
      .sens_step_a0(sens_step_a0), .sens_step_a1(sens_step_a1), .sens_fault_pin(sens_fault_pin));
   cpp_host_model cpp_host_model_inst (.clk(clk), .y_pins(y_pins), .bm_addr(bm_addr), .bm_wr_en(bm_wr_en),
      .bm_wdata(bm_wdata), .bm_rd_en(bm_rd_en), .bm_rdata(bm_rdata), .bm_rd_valid(bm_rd_valid));
   task automatic conclude();
      if (fail_count == 0 && check_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : conclude
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         fail_count++;
         $display("ERROR %0t got %h expected %h", $time, g, e);
      end
   endtask : chk
   // read a two-word location and compare it
   task automatic chk_rd(input logic [10:0] a, input logic [31:0] e);
      logic [31:0] d;
      cpp_host_model_inst.rd32(a, d);
      chk(d, e);
   endtask : chk_rd
   // one signed movement sample on one axis
   task automatic step(input int ax, input logic [15:0] s);
      @(posedge clk);
      sens_step_valid[ax] <= 1'b1;
      sens_step_a0 <= s;
      sens_step_a1 <= s;
      @(posedge clk);
      sens_step_valid <= 2'b00;
      repeat (4) @(posedge clk);
   endtask : step
   // preset held high, position checked, then moved while still held
   task automatic t_preset(input int ax, input logic [31:0] v);
      logic [10:0] o;
      o = (ax == 1) ? AXIS_STRIDE : 11'h000;
      cpp_host_model_inst.wr32(PRESET_LO + o, v);
      cpp_host_model_inst.set_y((ax == 1) ? Y_PRESET_A1 : Y_PRESET_A0, 1'b1);
      repeat (6) @(posedge clk);
      chk_rd(POS_CW_LO + o, v);
      chk_rd(POS_CCW_LO + o, v);
      step(ax, 16'h0005);
      chk_rd(POS_CW_LO + o, v + 32'h5);
      chk_rd(POS_CCW_LO + o, v - 32'h5);
      cpp_host_model_inst.pulse((ax == 1) ? Y_PRESET_A1 : Y_PRESET_A0, 0);
   endtask : t_preset
   // a preset edge that must leave axis 1 untouched
   task automatic t_refused();
      logic [31:0] d;
      cpp_host_model_inst.rd32(POS_CW_LO, d);
      cpp_host_model_inst.pulse(Y_PRESET_A0, 3);
      chk_rd(POS_CW_LO, d);
   endtask : t_refused
   // error flag and code seen, then a long clear request
   task automatic t_err(input logic [15:0] code);
      repeat (8) @(posedge clk);
      chk(32'(x_pins[X_ERROR_A0]), 32'h1);
      chk_rd(ERR_CODE_ADDR, {16'h0, code});
   endtask : t_err
   task automatic t_clear();
      cpp_host_model_inst.set_y(Y_ERR_CLEAR, 1'b1);
      repeat (16) @(posedge clk);
      cpp_host_model_inst.set_y(Y_ERR_CLEAR, 1'b0);
      repeat (4) @(posedge clk);
      chk(32'(x_pins[X_ERROR_A0]), 32'h0);
      chk_rd(ERR_CODE_ADDR, 32'h0);
   endtask : t_clear
   // main sequence
   initial begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      chk(x_pins, 32'h0);
      chk_rd(POS_CW_LO, 32'h0);
      chk_rd(ERR_CODE_ADDR, 32'h0);
      cpp_host_model_inst.wr(AXIS_EN_ADDR, 16'h0000);
      cpp_host_model_inst.set_y(Y_READY, 1'b1);
      repeat (6) @(posedge clk);
      chk(32'(x_pins[X_ONLINE]), 32'h1);
      t_preset(0, PV);
      t_preset(1, 32'h00ab_cdef);
      cpp_host_model_inst.wr32(INHIBIT_LO, 32'h1);
      t_refused();
      cpp_host_model_inst.wr32(INHIBIT_LO, 32'h2);
      cpp_host_model_inst.pulse(Y_PRESET_A0, 1);
      chk_rd(POS_CW_LO, PV);
      cpp_host_model_inst.wr32(INHIBIT_LO, 32'h0);
      cpp_host_model_inst.wr(PRESET_HI, 16'h0100);
      t_err(ERR_PRESET_RNG);
      chk_rd(PRESET_LO, PV);
      cpp_host_model_inst.pulse(Y_ERR_CLEAR, 4);
      chk(32'(x_pins[X_ERROR_A0]), 32'h1);
      t_clear();
      cpp_host_model_inst.wr(POS_CW_LO, 16'h1111);
      t_err(ERR_WR_BASE + 16'h2);
      chk_rd(POS_CW_LO, PV);
      t_clear();
      sens_fault_pin[0] <= 1'b1;
      t_err(ERR_SENSOR);
      chk(32'(x_pins[X_SFAULT_A0]), 32'h1);
      chk(x_pins, 32'h0000_0032);
      cpp_host_model_inst.wr32(PRESET_LO, 32'h0000_0777);
      t_refused();
      sens_fault_pin[0] <= 1'b0;
      t_clear();
      chk(32'(x_pins[X_SFAULT_A0]), 32'h0);
      cpp_host_model_inst.set_y(Y_READY, 1'b0);
      repeat (6) @(posedge clk);
      chk(32'(x_pins[X_ONLINE]), 32'h0);
      t_refused();
      conclude();
   end
   // hang guard, well beyond the expected run length
   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      conclude();
   end
endmodule : testbench
